/* File: src/crdic_pkg.sv */
package crdic_pkg;

  // ----------------------------------------------------------------------
  // widths and constants
  // ----------------------------------------------------------------------
  localparam int          CRDIC_IRQ_W      = 32;
  localparam int          CRDIC_ADDR_W     = 32;
  localparam int          CRDIC_LEVEL_W    = 6;
  localparam int          CRDIC_RSET_W     = 6;
  localparam logic [31:0] CRDIC_MASK_RST   = 32'h0000_0000;
  // core pipeline drain depth and the re-read period while held in reset
  localparam logic [3:0]  CRDIC_DRAIN_CYC  = 4'h4;
  localparam logic [3:0]  CRDIC_PULSE_PER  = 4'h8;
  localparam logic [3:0]  CRDIC_CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CRDIC_CNT_ONE    = 4'h1;
  localparam logic [5:0]  CRDIC_LEVEL_ZERO = 6'h00;

  // ----------------------------------------------------------------------
  // core run states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    CRDIC_RUN    = 5'b0_0001,
    CRDIC_DRAIN  = 5'b0_0010,
    CRDIC_INRST  = 5'b0_0100,
    CRDIC_PAUSED = 5'b0_1000,
    CRDIC_HSHAKE = 5'b1_0000
  } crdic_state_t;

endpackage : crdic_pkg

/* File: src/crdic_if.sv */
`timescale 1ns/1ps
`default_nettype none
// boundary between the core control end and the system side
interface crdic_if;
  import crdic_pkg::*;
  logic                     local_reset_request;
  logic                     reset_acknowledge_pulse;
  logic                     pre_reset_handshake_request;
  logic                     pre_reset_handshake_ack;
  logic                     debug_halt_request;
  logic                     debug_halt_acknowledge;
  logic                     debug_step;
  logic                     debug_resume;
  logic [CRDIC_IRQ_W-1:0]   irq_request;
  logic                     eic_valid;
  logic [CRDIC_ADDR_W-1:0]  eic_handler_addr;
  logic [CRDIC_RSET_W-1:0]  eic_reg_set;
  logic [CRDIC_LEVEL_W-1:0] eic_level;
  logic                     eic_nonmaskable;
  logic                     reset_read_strobe;

  modport core (
    input  local_reset_request, pre_reset_handshake_ack, debug_halt_request,
    input  debug_step, debug_resume, irq_request, eic_valid,
    input  eic_handler_addr, eic_reg_set, eic_level, eic_nonmaskable,
    output reset_acknowledge_pulse, pre_reset_handshake_request,
    output debug_halt_acknowledge, reset_read_strobe
  );
  modport system (
    output local_reset_request, pre_reset_handshake_ack, debug_halt_request,
    output debug_step, debug_resume, irq_request, eic_valid,
    output eic_handler_addr, eic_reg_set, eic_level, eic_nonmaskable,
    input  reset_acknowledge_pulse, pre_reset_handshake_request,
    input  debug_halt_acknowledge, reset_read_strobe
  );
endinterface : crdic_if
`default_nettype wire

/* File: src/crdic_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a vector of levels
module crdic_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,   // core clock
  input  wire logic         rst,   // async reset, high
  input  wire logic [W-1:0] d,     // raw level
  output logic      [W-1:0] q      // synchronised level
);
  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : crdic_sync2
`default_nettype wire

/* File: src/crdic_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - global reset resets core immediately
// - local request: drain pipeline, reset core only
// - requester holds request until acknowledge; crdic_system drops it as soon as the user releases it
// - one-cycle acknowledge, repeated while held
// - stay in reset, periodic discarded reads
// - ignore request while paused by debug
// - halt request pauses, traps, acknowledges
// - halt request while paused ignored
// - pre-reset handshake completes before reset
// - all exceptions use one common address; code: BREAK_ADDR for debug breaks, controller address when external
// - exceptions precise, pipeline drained first; code: debug breaks are taken without waiting for pipe_empty
// - external controller replaces internal one
// - external controller presents one interrupt
// - external level decides service time
// - nonmaskable ignores global enable
// - 32 level-sensitive request inputs
// - enable mask bit n gates input n
// - interrupt iff enable, request, mask
// - nesting allowed, no hardware priority
// - controller owns selection algorithm
module crdic_core
  import crdic_pkg::*;
#(
  parameter bit                    EXT_IRQ_CTRL   = 1'b0,
  parameter bit                    PRE_RESET_HS   = 1'b0,
  parameter logic [CRDIC_ADDR_W-1:0] EXC_ADDR     = 32'h0000_0020,
  parameter logic [CRDIC_ADDR_W-1:0] BREAK_ADDR   = 32'h0000_0040
) (
  input  wire logic                     clk,            // core clock
  input  wire logic                     rst,            // global reset
  crdic_if.core                         sys,            // system side
  input  wire logic                     mask_we,        // mask write
  input  wire logic [CRDIC_IRQ_W-1:0]   mask_wdata,     // mask data
  input  wire logic                     gie_we,         // enable write
  input  wire logic                     gie_wdata,      // enable data
  input  wire logic                     insn_retire,    // pipeline step
  input  wire logic                     pipe_empty,     // no insn in flight
  input  wire logic                     exc_ack,        // handler entered
  input  wire logic [CRDIC_LEVEL_W-1:0] cur_level,      // running level
  output logic      [CRDIC_IRQ_W-1:0]   irq_enable_mask,// mask readback
  output logic                          global_interrupt_enable, // enable
  output logic                          irq_pending,    // interrupt raised
  output logic                          exc_take,       // branch request
  output logic      [CRDIC_ADDR_W-1:0]  exc_target,     // branch address
  output logic      [CRDIC_RSET_W-1:0]  exc_reg_set,    // shadow set
  output logic                          core_in_reset,  // core held
  output logic                          core_paused     // debug paused
);

  // ----------------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------------
  typedef struct packed {
    crdic_state_t             st;
    logic [3:0]               cnt;
    logic                     ack;
    logic                     rd;
    logic                     hack;
    logic [CRDIC_IRQ_W-1:0]   mask;
    logic                     gie;
    logic                     take;
    logic [CRDIC_ADDR_W-1:0]  tgt;
    logic [CRDIC_RSET_W-1:0]  rset;
    logic                     pend;
  } crdic_core_t;

  crdic_core_t r;
  crdic_core_t next_r;

  logic                   rreq_s;
  logic                   hreq_s;
  logic                   hs_ack_s;
  logic [CRDIC_IRQ_W-1:0] irq_s;
  logic                   int_irq;
  logic                   ext_irq;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  crdic_sync2 #(.W(1)) u_sync_rreq (
    .clk (clk),
    .rst (rst),
    .d   (sys.local_reset_request),
    .q   (rreq_s)
  );
  crdic_sync2 #(.W(1)) u_sync_hreq (
    .clk (clk),
    .rst (rst),
    .d   (sys.debug_halt_request),
    .q   (hreq_s)
  );
  crdic_sync2 #(.W(1)) u_sync_hs (
    .clk (clk),
    .rst (rst),
    .d   (sys.pre_reset_handshake_ack),
    .q   (hs_ack_s)
  );
  // level-sensitive lines; a drop takes effect the cycle after sampling
  crdic_sync2 #(.W(CRDIC_IRQ_W)) u_sync_irq (
    .clk (clk),
    .rst (rst),
    .d   (sys.irq_request),
    .q   (irq_s)
  );

  // ----------------------------------------------------------------------
  // interrupt conditions
  // ----------------------------------------------------------------------
  // no priority encoding: any enabled line raises the single condition
  assign int_irq = !EXT_IRQ_CTRL && r.gie &&
                   |(irq_s & r.mask);
  // level compared to running level; nonmaskable bypasses the enable
  assign ext_irq = EXT_IRQ_CTRL && sys.eic_valid &&
                   (sys.eic_nonmaskable ||
                    (r.gie && sys.eic_level > cur_level));

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.ack  = 1'b0;
    next_r.rd   = 1'b0;
    next_r.take = 1'b0;
    // mask writes only exist with the internal controller
    if (mask_we && !EXT_IRQ_CTRL) begin
      next_r.mask = mask_wdata;
    end
    if (gie_we) begin
      next_r.gie = gie_wdata;
    end
    next_r.pend = int_irq || ext_irq;
    case (r.st)
      CRDIC_RUN: begin
        if (hreq_s) begin
          next_r.st   = CRDIC_PAUSED;
          next_r.take = 1'b1;
          next_r.tgt  = BREAK_ADDR;
        end else if (rreq_s) begin
          next_r.st  = CRDIC_DRAIN;
          next_r.cnt = CRDIC_DRAIN_CYC;
        end else if (next_r.pend && pipe_empty && !exc_ack) begin
          // taken only on an empty pipe so the fault is precise
          next_r.take = 1'b1;
          if (EXT_IRQ_CTRL) begin
            next_r.tgt  = sys.eic_handler_addr;
            next_r.rset = sys.eic_reg_set;
          end else begin
            next_r.tgt  = EXC_ADDR;
            next_r.rset = '0;
          end
        end
      end
      CRDIC_DRAIN: begin
        // finish in-flight work before resetting
        if (insn_retire && r.cnt != CRDIC_CNT_ZERO) begin
          next_r.cnt = r.cnt - CRDIC_CNT_ONE;
        end
        if (pipe_empty || r.cnt == CRDIC_CNT_ZERO) begin
          if (PRE_RESET_HS) begin
            next_r.st   = CRDIC_HSHAKE;
            next_r.hack = 1'b1;
          end else begin
            next_r.st  = CRDIC_INRST;
            next_r.ack = 1'b1;
            next_r.cnt = CRDIC_PULSE_PER;
          end
        end
      end
      CRDIC_HSHAKE: begin
        if (hs_ack_s) begin
          next_r.hack = 1'b0;
          next_r.st   = CRDIC_INRST;
          next_r.ack  = 1'b1;
          next_r.cnt  = CRDIC_PULSE_PER;
        end
      end
      CRDIC_INRST: begin
        next_r.mask = CRDIC_MASK_RST;
        next_r.gie  = 1'b0;
        if (!rreq_s) begin
          next_r.st = CRDIC_RUN;
        end else if (r.cnt == CRDIC_CNT_ONE) begin
          // re-read of the reset address, data discarded
          next_r.ack = 1'b1;
          next_r.rd  = 1'b1;
          next_r.cnt = CRDIC_PULSE_PER;
        end else begin
          next_r.cnt = r.cnt - CRDIC_CNT_ONE;
        end
      end
      CRDIC_PAUSED: begin
        // halt and reset requests are ignored while paused
        if (sys.debug_resume || sys.debug_step) begin
          next_r.st = CRDIC_RUN;
        end
      end
      default: begin
        next_r.st = CRDIC_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // state register; async reset hits at once, nothing waits
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r      <= '0;
      r.st   <= CRDIC_RUN;
      r.mask <= CRDIC_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign sys.reset_acknowledge_pulse     = r.ack;
  assign sys.reset_read_strobe           = r.rd;
  assign sys.pre_reset_handshake_request = r.hack;
  assign sys.debug_halt_acknowledge      = (r.st == CRDIC_PAUSED);
  assign irq_enable_mask                 = r.mask;
  assign global_interrupt_enable         = r.gie;
  assign irq_pending                     = r.pend;
  assign exc_take                        = r.take;
  assign exc_target                      = r.tgt;
  assign exc_reg_set                     = r.rset;
  assign core_in_reset                   = (r.st == CRDIC_INRST);
  assign core_paused                     = (r.st == CRDIC_PAUSED);

endmodule : crdic_core
`default_nettype wire

/* File: src/crdic_system.sv */
`timescale 1ns/1ps
`default_nettype none
// system side: reset requester, debug module and external controller
module crdic_system
  import crdic_pkg::*;
(
  input  wire logic                     clk,          // core clock
  input  wire logic                     rst,          // async reset
  crdic_if.system                       sys,          // core side
  input  wire logic                     u_reset_req,  // want local reset
  input  wire logic                     u_halt,       // want halt
  input  wire logic                     u_step,       // single step
  input  wire logic                     u_resume,     // resume
  input  wire logic [CRDIC_IRQ_W-1:0]   u_irq,        // interrupt sources
  input  wire logic [CRDIC_IRQ_W-1:0]   u_nmi_sel,    // nmi configuration
  input  wire logic [CRDIC_ADDR_W-1:0]  u_vec_base,   // handler base
  output logic                          u_reset_done  // acknowledge seen
);
  typedef struct packed {
    logic                     rreq;
    logic                     done;
    logic                     hs;
    logic                     valid;
    logic [CRDIC_ADDR_W-1:0]  addr;
    logic [CRDIC_LEVEL_W-1:0] lvl;
    logic                     nmi;
  } crdic_sys_t;

  crdic_sys_t r;
  crdic_sys_t next_r;

  // ----------------------------------------------------------------------
  // request holding and simple lowest-index selection
  // ----------------------------------------------------------------------
  always_comb begin
    next_r       = r;
    next_r.done  = 1'b0;
    // follow the user request level; a user release drops it even before acknowledge
    if (u_reset_req) begin
      next_r.rreq = 1'b1;
    end else if (!u_reset_req) begin
      next_r.rreq = 1'b0;
    end
    if (sys.reset_acknowledge_pulse) begin
      next_r.done = 1'b1;
    end
    next_r.hs    = sys.pre_reset_handshake_request;
    next_r.valid = |u_irq;
    next_r.addr  = u_vec_base;
    next_r.lvl   = CRDIC_LEVEL_ZERO;
    next_r.nmi   = 1'b0;
    // any selection is legal to the core; this one favours low index
    for (int i = CRDIC_IRQ_W - 1; i >= 0; i--) begin
      if (u_irq[i]) begin
        next_r.addr = u_vec_base + CRDIC_ADDR_W'(i);
        next_r.nmi  = u_nmi_sel[i];
        next_r.lvl  = u_nmi_sel[i] ? CRDIC_LEVEL_ZERO :
                      CRDIC_LEVEL_W'(CRDIC_IRQ_W - i);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sys.local_reset_request     = r.rreq;
  assign sys.pre_reset_handshake_ack = r.hs;
  assign sys.debug_halt_request      = u_halt;
  assign sys.debug_step              = u_step;
  assign sys.debug_resume            = u_resume;
  assign sys.irq_request             = u_irq;
  assign sys.eic_valid               = r.valid;
  assign sys.eic_handler_addr        = r.addr;
  assign sys.eic_reg_set             = '0;
  assign sys.eic_level               = r.lvl;
  assign sys.eic_nonmaskable         = r.nmi;
  assign u_reset_done                = r.done;
endmodule : crdic_system
`default_nettype wire

/* File: bench/crdic_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// boundary checker for the reset and debug handshakes
module crdic_properties (
  input wire logic clk,                     // core clock
  input wire logic rst,                     // global reset
  input wire logic local_reset_request,     // local reset level
  input wire logic reset_acknowledge_pulse, // reset taken pulse
  input wire logic reset_read_strobe,       // discarded read
  input wire logic debug_halt_request,      // halt level
  input wire logic debug_halt_acknowledge,  // paused level
  input wire logic debug_step,              // single step
  input wire logic debug_resume             // resume
);
  // ----------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------
  // recent release history, so the two-flop sync lag is not flagged
  logic [2:0] rel_hist;
  logic [2:0] next_rel_hist;
  always_comb next_rel_hist = {rel_hist[1:0], debug_step | debug_resume};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rel_hist <= 3'h0;
    else     rel_hist <= next_rel_hist;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence ack_s;   reset_acknowledge_pulse; endsequence
  sequence quiet_s; !local_reset_request [*6]; endsequence
  sequence rel_quiet_s;
    rel_hist == 3'h0 && !debug_step && !debug_resume;
  endsequence
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  ack_pulse_one_a: assert property (
    ack_s |=> !reset_acknowledge_pulse)
    else $error("reset acknowledge longer than one cycle");
  ack_has_req_a: assert property (
    ack_s |-> local_reset_request ||
    $past(local_reset_request) || $past(local_reset_request, 2) ||
    $past(local_reset_request, 3))
    else $error("reset acknowledge without a request");
  ack_repeat_a: assert property (ack_s ##0 local_reset_request
    |-> ##[1:10] (reset_acknowledge_pulse || !local_reset_request))
    else $error("reset acknowledge not repeated while held");
  strobe_has_req_a: assert property (reset_read_strobe |->
    local_reset_request || $past(local_reset_request) ||
    $past(local_reset_request, 2) || $past(local_reset_request, 3))
    else $error("reset address read outside reset");
  idle_quiet_a: assert property (quiet_s |->
    !reset_acknowledge_pulse && !reset_read_strobe)
    else $error("reset activity after request dropped");
  halt_ack_a: assert property ($rose(debug_halt_request) &&
    !local_reset_request && !debug_halt_acknowledge
    |-> ##[1:12] debug_halt_acknowledge)
    else $error("halt request not acknowledged");
  halt_hold_a: assert property (
    debug_halt_acknowledge ##0 rel_quiet_s
    |=> debug_halt_acknowledge)
    else $error("halt acknowledge dropped while paused");
  paused_no_ack_a: assert property (debug_halt_acknowledge &&
    $past(debug_halt_acknowledge, 3) |-> !reset_acknowledge_pulse)
    else $error("reset acknowledged while paused");
endmodule // crdic_properties
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crdic_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mask_we = 1'b0, gie_we = 1'b0, gie_wdata = 1'b0;
  logic [31:0] mask_wdata = 32'h0000_0000;
  logic        insn_retire = 1'b0, pipe_empty = 1'b1;
  logic        u_reset_req = 1'b0, u_halt = 1'b0, u_resume = 1'b0;
  logic        u_step = 1'b0;
  logic        x_rreq = 1'b0;
  logic [31:0] x_irq = 32'h0000_0000, x_nmi = 32'h0000_0000;
  logic [31:0] x_mask, x_tgt;
  logic [5:0]  x_rset;
  logic        x_pend, x_take, x_inrst, u_done;
  logic [31:0] u_irq = 32'h0000_0000;
  logic [31:0] irq_enable_mask, exc_target;
  logic [5:0]  exc_reg_set;
  logic        global_interrupt_enable, irq_pending, exc_take;
  logic        core_in_reset, core_paused;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n_ack, n_rd, n_done;
  logic [31:0] t_mask [4] = '{32'h8000_0000, 32'h8000_0000,
                              32'h8000_0000, 32'h0000_0001};
  logic [31:0] t_irq  [4] = '{32'h8000_0000, 32'h8000_0000,
                              32'h4000_0000, 32'h0000_0001};
  logic        t_gie  [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic        t_exp;

  always #2.5 clk = ~clk;

  crdic_if sif ();
  crdic_core crdic_core_i (.clk(clk), .rst(rst), .sys(sif),
    .mask_we(mask_we), .mask_wdata(mask_wdata), .gie_we(gie_we),
    .gie_wdata(gie_wdata), .insn_retire(insn_retire),
    .pipe_empty(pipe_empty), .exc_ack(1'b0), .cur_level(6'h05),
    .irq_enable_mask(irq_enable_mask),
    .global_interrupt_enable(global_interrupt_enable),
    .irq_pending(irq_pending), .exc_take(exc_take),
    .exc_target(exc_target), .exc_reg_set(exc_reg_set),
    .core_in_reset(core_in_reset), .core_paused(core_paused));
  crdic_system crdic_system_i (.clk(clk), .rst(rst), .sys(sif),
    .u_reset_req(u_reset_req), .u_halt(u_halt), .u_step(u_step),
    .u_resume(u_resume), .u_irq(u_irq), .u_nmi_sel(32'h0000_0000),
    .u_vec_base(32'h0000_0100), .u_reset_done(u_done));
  // second pair: external controller and pre-reset handshake configured
  crdic_if sifx ();
  crdic_core #(.EXT_IRQ_CTRL(1'b1), .PRE_RESET_HS(1'b1)) crdic_core_x_i (
    .clk(clk), .rst(rst), .sys(sifx), .mask_we(mask_we),
    .mask_wdata(mask_wdata), .gie_we(gie_we), .gie_wdata(gie_wdata),
    .insn_retire(insn_retire), .pipe_empty(pipe_empty), .exc_ack(1'b0),
    .cur_level(6'h05), .irq_enable_mask(x_mask),
    .global_interrupt_enable(), .irq_pending(x_pend), .exc_take(x_take),
    .exc_target(x_tgt), .exc_reg_set(x_rset),
    .core_in_reset(x_inrst), .core_paused());
  crdic_system crdic_system_x_i (.clk(clk), .rst(rst), .sys(sifx),
    .u_reset_req(x_rreq), .u_halt(1'b0), .u_step(1'b0),
    .u_resume(1'b0), .u_irq(x_irq), .u_nmi_sel(x_nmi),
    .u_vec_base(32'h0000_0100), .u_reset_done());
  crdic_properties crdic_properties_i (.clk(clk), .rst(rst),
    .local_reset_request(sif.local_reset_request),
    .reset_acknowledge_pulse(sif.reset_acknowledge_pulse),
    .reset_read_strobe(sif.reset_read_strobe),
    .debug_halt_request(sif.debug_halt_request),
    .debug_halt_acknowledge(sif.debug_halt_acknowledge),
    .debug_step(sif.debug_step), .debug_resume(sif.debug_resume));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded watch; a missed expected event ends the run at once
  task automatic watch(input string nm, ref logic s, input int n,
                       input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(negedge clk);
      if (s === 1'b1) seen = 1'b1;
    end
    check(nm, 32'(seen), 32'(exp));
    if (exp && !seen) end_sim();
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check("mask_rst", irq_enable_mask, CRDIC_MASK_RST);
    check("gie_rst", 32'(global_interrupt_enable), 32'h0);
    check("in_reset_rst", 32'(core_in_reset), 32'h0);
    // local reset: no ack while instructions are still in flight
    pipe_empty = 1'b0;
    u_reset_req = 1'b1;
    watch("early_ack", sif.reset_acknowledge_pulse, 12, 1'b0);
    insn_retire = 1'b1;
    watch("drain_ack", sif.reset_acknowledge_pulse, 16, 1'b1);
    insn_retire = 1'b0;
    pipe_empty = 1'b1;
    check("in_reset", 32'(core_in_reset), 32'h1);
    n_ack = 0;
    n_rd = 0;
    n_done = 0;
    repeat (32) begin
      @(negedge clk);
      if (sif.reset_acknowledge_pulse === 1'b1) n_ack++;
      if (sif.reset_read_strobe === 1'b1) n_rd++;
      if (u_done === 1'b1) n_done++;
    end
    check("ack_count", 32'(n_ack), 32'h0000_0004);
    check("done_count", 32'(n_done), 32'h0000_0004);
    check("read_count", 32'(n_rd), 32'h0000_0004);
    u_reset_req = 1'b0;
    repeat (8) @(negedge clk);
    check("left_reset", 32'(core_in_reset), 32'h0);
    // interrupt condition table, mask edge bits included
    for (int k = 0; k < 4; k++) begin
      t_exp = t_gie[k] && ((t_mask[k] & t_irq[k]) != 32'h0000_0000);
      mask_we = 1'b1;
      mask_wdata = t_mask[k];
      gie_we = 1'b1;
      gie_wdata = t_gie[k];
      @(negedge clk);
      mask_we = 1'b0;
      gie_we = 1'b0;
      check("mask_rb", irq_enable_mask, t_mask[k]);
      u_irq = t_irq[k];
      watch("irq_pending", irq_pending, 8, t_exp);
      if (t_exp) begin
        repeat (2) @(negedge clk);
        check("exc_target", exc_target, 32'h0000_0020);
        check("exc_take", 32'(exc_take), 32'h0000_0001);
      end
      u_irq = 32'h0000_0000;
      repeat (4) @(negedge clk);
      watch("irq_drop", irq_pending, 6, 1'b0);
    end
    // debug halt, then reset requests ignored while paused
    u_halt = 1'b1;
    watch("halt_ack", sif.debug_halt_acknowledge, 12, 1'b1);
    u_halt = 1'b0;
    repeat (2) @(negedge clk);
    check("paused", 32'(core_paused), 32'h1);
    check("break_addr", exc_target, 32'h0000_0040);
    u_reset_req = 1'b1;
    watch("paused_ack", sif.reset_acknowledge_pulse, 16, 1'b0);
    u_halt = 1'b1;
    repeat (4) @(negedge clk);
    // the dropped halt must clear the synchroniser before resuming,
    // or the core would halt again right after it leaves the pause
    u_halt = 1'b0;
    repeat (4) @(negedge clk);
    check("still_paused", 32'(core_paused), 32'h1);
    check("halt_ack_held", 32'(sif.debug_halt_acknowledge),
          32'h1);
    u_resume = 1'b1;
    @(negedge clk);
    u_resume = 1'b0;
    watch("resume_ack", sif.reset_acknowledge_pulse, 24, 1'b1);
    check("resume_reset", 32'(core_in_reset), 32'h1);
    check("halt_ack_off", 32'(sif.debug_halt_acknowledge),
          32'h0);
    u_reset_req = 1'b0;
    repeat (10) @(negedge clk);
    // a single step also opens a window for a held reset request
    u_halt = 1'b1;
    watch("halt_again", sif.debug_halt_acknowledge, 12, 1'b1);
    u_halt = 1'b0;
    u_reset_req = 1'b1;
    repeat (8) @(negedge clk);
    u_step = 1'b1;
    @(negedge clk);
    u_step = 1'b0;
    watch("step_ack", sif.reset_acknowledge_pulse, 24, 1'b1);
    check("step_reset", 32'(core_in_reset), 32'h1);
    u_reset_req = 1'b0;
    repeat (10) @(negedge clk);
    // external controller pair: mask refused, nonmaskable, level, precise
    mask_we = 1'b1;
    mask_wdata = 32'hffff_ffff;
    gie_we = 1'b1;
    gie_wdata = 1'b0;
    @(negedge clk);
    mask_we = 1'b0;
    gie_we = 1'b0;
    check("x_mask", x_mask, CRDIC_MASK_RST);
    x_nmi = 32'h4000_0000;
    x_irq = 32'h4000_0000;
    watch("x_nmi", x_pend, 8, 1'b1);
    check("x_nmi_tgt", x_tgt, 32'h0000_011e);
    check("x_rset", 32'(x_rset), 32'h0000_0000);
    x_irq = 32'h0000_0000;
    x_nmi = 32'h0000_0000;
    gie_we = 1'b1;
    gie_wdata = 1'b1;
    @(negedge clk);
    gie_we = 1'b0;
    repeat (4) @(negedge clk);
    // line 30 carries a level below the running level
    x_irq = 32'h4000_0000;
    watch("x_low_level", x_pend, 8, 1'b0);
    // line 3 is above it; a busy pipe holds the branch back
    pipe_empty = 1'b0;
    x_irq = 32'h0000_0008;
    watch("x_high_level", x_pend, 8, 1'b1);
    check("x_no_take", 32'(x_take), 32'h0000_0000);
    pipe_empty = 1'b1;
    @(negedge clk);
    check("x_take", 32'(x_take), 32'h0000_0001);
    check("x_tgt", x_tgt, 32'h0000_0103);
    // local reset waits for the pre-reset handshake
    x_irq = 32'h0000_0000;
    x_rreq = 1'b1;
    watch("x_hreq", sifx.pre_reset_handshake_request, 16, 1'b1);
    check("x_hs_early", 32'(x_inrst), 32'h0000_0000);
    watch("x_hs_ack", sifx.reset_acknowledge_pulse, 16, 1'b1);
    check("x_hs_reset", 32'(x_inrst), 32'h0000_0001);
    x_rreq = 1'b0;
    repeat (10) @(negedge clk);
    end_sim();
  end
endmodule // tb
`default_nettype wire
